// [bclr_branch_pkg.sv]
package bclr_branch_pkg;
	// ***********************************
	// opcode fields
	// ***********************************
	localparam logic [7:0] OPC_BRANCH_ON_CARRY = 8'he2;
	localparam logic [3:0] OPC_CLEAR_REG_BIT = 4'h9;
	localparam int OPC_HI_POS = 8;
	localparam int BIT_SEL_POS = 9;
	localparam int ACCESS_SEL_POS = 8;
	localparam logic [7:0] INDEXED_LIMIT = 8'h5f;
	localparam logic [7:0] ACCESS_SPLIT_STD = 8'h80;
	localparam logic [7:0] ACCESS_SPLIT_EXT = 8'h60;
	localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;
	localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
	localparam int DATA_ADDR_W = 12;

	// ***********************************
	// instruction cycle timing
	// ***********************************
	localparam int QUARTERS = 4;
	localparam int CLK_PERIOD_NS = 10;
	localparam int QUARTER_NS = 10;
	localparam int QUARTER_CLKS = (QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ***********************************
	// register map (byte addresses)
	// ***********************************
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_BANK = 8'h04;
	localparam logic [7:0] REG_INDEX_BASE = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0c;
	localparam int CTRL_EXT_POS = 0;
	localparam int CTRL_EXEC_POS = 1;
	localparam logic [1:0] CTRL_RESET = 2'h2;
	localparam logic [3:0] BANK_RESET = 4'h0;
	localparam logic [11:0] INDEX_BASE_RESET = 12'h000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [3:0] {
		S_IDLE = 4'b0001,
		S_BRANCH = 4'b0010,
		S_CLEAR = 4'b0100,
		S_FLUSH = 4'b1000
	} exec_state_t;

	typedef enum logic [2:0] {
		R_CTRL,
		R_BANK,
		R_INDEX,
		R_STATUS,
		R_NONE
	} reg_sel_t;
endpackage

// [carry_branch_and_bit_clear_exec.sv]
// Our own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
// Summary of operation
// [RULE1] opcode E2 plus offset branches only when carry is one; flags untouched.
// [RULE2] taken target is the incremented counter plus twice the signed offset.
// [RULE3] not taken: one cycle; taken: counter written in Q4, then one empty cycle.
// [RULE4] opcode 9 with bit index, access bit, address clears that register bit.
// [RULE5] access bit zero selects the fixed access bank.
// [RULE6] access bit one joins bank select with the address.
// [RULE7] access zero, extended set on, address up to 5F: indexed literal offset.
// [RULE8] bit clear is read, modify, write within one cycle, no flags changed.
module carry_branch_and_bit_clear_exec import bclr_branch_pkg::*; #(
	parameter int PC_W = 21
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// instruction from fetch
	input wire logic [15:0] instr,
	input wire logic instrValid,
	input wire logic carryFlag,
	input wire logic [PC_W-1:0] pcNext,
	output logic fetchStall,
	output logic instrTaken,
	// program counter load
	output logic pcLoad,
	output logic [PC_W-1:0] pcTarget,
	// data memory
	output logic [DATA_ADDR_W-1:0] memAddr,
	output logic memRd,
	input wire logic [7:0] memRdata,
	output logic memWr,
	output logic [7:0] memWdata,
	// axi4-lite register slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	initial begin
		if (PC_W < 10 || PC_W > 32) $error("PC_W must lie in 10..32");
	end

	// ***********************************
	// helpers
	// ***********************************
	function automatic reg_sel_t decodeReg(input logic [7:0] a);
		case (a)
			REG_CTRL: decodeReg = R_CTRL;
			REG_BANK: decodeReg = R_BANK;
			REG_INDEX_BASE: decodeReg = R_INDEX;
			REG_STATUS: decodeReg = R_STATUS;
			default: decodeReg = R_NONE;
		endcase
	endfunction

	function automatic logic [31:0] mergeStrb(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] strb);
		mergeStrb = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) mergeStrb[8*i +: 8] = nw[8*i +: 8];
		end
	endfunction

	// operand address for the bit clear, in the three addressing modes
	function automatic logic [DATA_ADDR_W-1:0] operandAddr(input logic [7:0] f, input logic acc,
			input logic ext, input logic [3:0] bank, input logic [11:0] base);
		if (acc) begin
			operandAddr = {bank, f}; // [RULE6]
		end else if (ext && f <= INDEXED_LIMIT) begin
			operandAddr = base + {4'h0, f}; // [RULE7]
		end else if (f >= (ext ? ACCESS_SPLIT_EXT : ACCESS_SPLIT_STD)) begin
			operandAddr = {ACCESS_HIGH_BANK, f}; // [RULE5]
		end else begin
			operandAddr = {ACCESS_LOW_BANK, f}; // [RULE5]
		end
	endfunction

	// ***********************************
	// state
	// ***********************************
	typedef struct packed {
		exec_state_t state;
		logic [15:0] ir;
		logic carry;
		logic [PC_W-1:0] pcBase;
		logic taken;
		logic lastTaken;
		logic [7:0] branchCnt;
		logic [7:0] clearCnt;
		logic stall;
		logic take;
		logic pcLoad;
		logic [PC_W-1:0] pcTarget;
		logic [DATA_ADDR_W-1:0] memAddr;
		logic memRd;
		logic memWr;
		logic [7:0] memWdata;
		logic [7:0] rdSeen;
		logic [1:0] ctrl;
		logic [3:0] bank;
		logic [11:0] idxBase;
		logic awReady;
		logic awHeld;
		logic [7:0] awAddr;
		logic wReady;
		logic wHeld;
		logic [31:0] wData;
		logic [3:0] wStrb;
		logic bValid;
		logic [1:0] bResp;
		logic arReady;
		logic rValid;
		logic [31:0] rData;
		logic [1:0] rResp;
	} exec_st_t;

	exec_st_t st_q, st_d;
	logic [QUARTERS-1:0] q;

	quarter_phase_gen #(.DIV(QUARTER_CLKS)) u_phase (
		.clk(clk),
		.rst_b(rst_b),
		.qPulse(q)
	);

	// ***********************************
	// next state
	// ***********************************
	always_comb begin
		logic [31:0] cur;
		logic [31:0] nw;
		logic [2:0] bsel;
		cur = '0;
		nw = '0;
		bsel = st_q.ir[BIT_SEL_POS +: 3];
		st_d = st_q;
		st_d.pcLoad = 1'b0;
		st_d.take = 1'b0;

		case (st_q.state)
			S_IDLE: begin
				st_d.stall = 1'b0;
				if (q[0] && instrValid && st_q.ctrl[CTRL_EXEC_POS]) begin
					st_d.ir = instr;
					st_d.carry = carryFlag;
					st_d.pcBase = pcNext;
					if (instr[15:OPC_HI_POS] == OPC_BRANCH_ON_CARRY) begin
						st_d.state = S_BRANCH; // [RULE1]
						st_d.take = 1'b1;
					end else if (instr[15:12] == OPC_CLEAR_REG_BIT) begin
						st_d.state = S_CLEAR; // [RULE4]
						st_d.take = 1'b1;
					end
				end
			end
			S_BRANCH: begin
				if (q[2]) begin
					st_d.taken = st_q.carry; // [RULE1]
					st_d.pcTarget = st_q.pcBase + {{(PC_W-9){st_q.ir[7]}}, st_q.ir[7:0], 1'b0}; // [RULE2]
				end
				if (q[3]) begin
					st_d.lastTaken = st_q.taken;
					st_d.branchCnt = st_q.branchCnt + 8'h01;
					if (st_q.taken) begin
						st_d.pcLoad = 1'b1; // [RULE3]
						st_d.stall = 1'b1;
						st_d.state = S_FLUSH;
					end else begin
						st_d.state = S_IDLE; // [RULE3]
					end
				end
			end
			S_CLEAR: begin
				if (q[1]) begin
					st_d.memAddr = operandAddr(st_q.ir[7:0], st_q.ir[ACCESS_SEL_POS],
						st_q.ctrl[CTRL_EXT_POS], st_q.bank, st_q.idxBase);
					st_d.memRd = 1'b1; // [RULE8]
				end
				if (q[2]) begin
					// only the selected bit changes; the rest is written back as read
					st_d.rdSeen = memRdata;
					st_d.memWdata = memRdata & ~(8'h01 << bsel); // [RULE4]
					st_d.memRd = 1'b0;
					st_d.memWr = 1'b1; // [RULE8]
				end
				if (q[3]) begin
					st_d.memWr = 1'b0;
					st_d.clearCnt = st_q.clearCnt + 8'h01;
					st_d.state = S_IDLE;
				end
			end
			S_FLUSH: begin
				// the fetched word behind a taken branch is discarded here
				if (q[3]) begin
					st_d.stall = 1'b0;
					st_d.state = S_IDLE; // [RULE3]
				end
			end
			default: begin
				st_d.state = S_IDLE;
				st_d.stall = 1'b0;
				st_d.memRd = 1'b0;
				st_d.memWr = 1'b0;
			end
		endcase

		// register writes: address and data may arrive in either order
		if (s_axi_awvalid && st_q.awReady) begin
			st_d.awHeld = 1'b1;
			st_d.awAddr = s_axi_awaddr;
			st_d.awReady = 1'b0;
		end
		if (s_axi_wvalid && st_q.wReady) begin
			st_d.wHeld = 1'b1;
			st_d.wData = s_axi_wdata;
			st_d.wStrb = s_axi_wstrb;
			st_d.wReady = 1'b0;
		end
		if (st_q.awHeld && st_q.wHeld && !st_q.bValid) begin
			st_d.awHeld = 1'b0;
			st_d.wHeld = 1'b0;
			st_d.bValid = 1'b1;
			st_d.bResp = RESP_OKAY;
			case (decodeReg(st_q.awAddr))
				R_CTRL: begin
					cur = {30'h0, st_q.ctrl};
					nw = mergeStrb(cur, st_q.wData, st_q.wStrb);
					st_d.ctrl = nw[1:0];
				end
				R_BANK: begin
					cur = {28'h0, st_q.bank};
					nw = mergeStrb(cur, st_q.wData, st_q.wStrb);
					st_d.bank = nw[3:0];
				end
				R_INDEX: begin
					cur = {20'h0, st_q.idxBase};
					nw = mergeStrb(cur, st_q.wData, st_q.wStrb);
					st_d.idxBase = nw[11:0];
				end
				R_STATUS: st_d.bResp = RESP_OKAY;
				default: st_d.bResp = RESP_SLVERR;
			endcase
		end
		if (st_q.bValid && s_axi_bready) begin
			st_d.bValid = 1'b0;
			st_d.awReady = 1'b1;
			st_d.wReady = 1'b1;
		end

		// register reads
		if (s_axi_arvalid && st_q.arReady) begin
			st_d.arReady = 1'b0;
			st_d.rValid = 1'b1;
			st_d.rResp = RESP_OKAY;
			case (decodeReg(s_axi_araddr))
				R_CTRL: st_d.rData = {30'h0, st_q.ctrl};
				R_BANK: st_d.rData = {28'h0, st_q.bank};
				R_INDEX: st_d.rData = {20'h0, st_q.idxBase};
				R_STATUS: st_d.rData = {st_q.clearCnt, st_q.branchCnt, 10'h0, st_q.lastTaken,
					st_q.stall, st_q.state};
				default: begin
					st_d.rData = '0;
					st_d.rResp = RESP_SLVERR;
				end
			endcase
		end
		if (st_q.rValid && s_axi_rready) begin
			st_d.rValid = 1'b0;
			st_d.arReady = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_q <= '0;
			st_q.state <= S_IDLE;
			st_q.ctrl <= CTRL_RESET;
			st_q.bank <= BANK_RESET;
			st_q.idxBase <= INDEX_BASE_RESET;
			st_q.awReady <= 1'b1;
			st_q.wReady <= 1'b1;
			st_q.arReady <= 1'b1;
		end else begin
			st_q <= st_d;
		end
	end

	// ***********************************
	// outputs
	// ***********************************
	assign fetchStall = st_q.stall;
	assign instrTaken = st_q.take;
	assign pcLoad = st_q.pcLoad;
	assign pcTarget = st_q.pcTarget;
	assign memAddr = st_q.memAddr;
	assign memRd = st_q.memRd;
	assign memWr = st_q.memWr;
	assign memWdata = st_q.memWdata;
	assign s_axi_awready = st_q.awReady;
	assign s_axi_wready = st_q.wReady;
	assign s_axi_bresp = st_q.bResp;
	assign s_axi_bvalid = st_q.bValid;
	assign s_axi_arready = st_q.arReady;
	assign s_axi_rdata = st_q.rData;
	assign s_axi_rresp = st_q.rResp;
	assign s_axi_rvalid = st_q.rValid;

	// ***********************************
	// checks
	// ***********************************
	a_branch_decode: assert property (@(posedge clk) disable iff (!rst_b) // [RULE1]
		st_q.state == S_IDLE && q[0] && instrValid && st_q.ctrl[CTRL_EXEC_POS]
		&& instr[15:8] == 8'he2 |=> st_q.state == S_BRANCH && st_q.carry == $past(carryFlag))
		else $error("branch on carry not decoded");
	a_no_carry_no_load: assert property (@(posedge clk) disable iff (!rst_b) // [RULE1]
		st_q.state == S_BRANCH && q[3] && !st_q.carry |=> !pcLoad && st_q.state == S_IDLE)
		else $error("branch taken without carry");
	a_target_value: assert property (@(posedge clk) disable iff (!rst_b) // [RULE2]
		pcLoad |-> pcTarget == st_q.pcBase + {{(PC_W-9){st_q.ir[7]}}, st_q.ir[7:0], 1'b0})
		else $error("branch target wrong");
	a_flush_after_load: assert property (@(posedge clk) disable iff (!rst_b) // [RULE3]
		pcLoad |-> fetchStall && st_q.state == S_FLUSH ##1 (!pcLoad throughout (st_q.state == S_FLUSH) [*3]))
		else $error("taken branch lacks empty cycle");
	a_clear_decode: assert property (@(posedge clk) disable iff (!rst_b) // [RULE4]
		st_q.state == S_IDLE && q[0] && instrValid && st_q.ctrl[CTRL_EXEC_POS]
		&& instr[15:12] == 4'h9 |=> st_q.state == S_CLEAR)
		else $error("bit clear not decoded");
	a_clear_bit_zero: assert property (@(posedge clk) disable iff (!rst_b) // [RULE4]
		memWr |-> memWdata[st_q.ir[11:9]] == 1'b0
		&& (memWdata | (8'h01 << st_q.ir[11:9])) == (st_q.rdSeen | (8'h01 << st_q.ir[11:9])))
		else $error("bit clear changed wrong bits");
	a_access_bank: assert property (@(posedge clk) disable iff (!rst_b) // [RULE5]
		memRd && !st_q.ir[8] && !(st_q.ctrl[0] && st_q.ir[7:0] <= 8'h5f)
		|-> memAddr[7:0] == st_q.ir[7:0] && (memAddr[11:8] == 4'h0 || memAddr[11:8] == 4'hf))
		else $error("access bank address wrong");
	a_banked_addr: assert property (@(posedge clk) disable iff (!rst_b) // [RULE6]
		memRd && st_q.ir[8] |-> memAddr == {st_q.bank, st_q.ir[7:0]})
		else $error("banked address wrong");
	a_indexed_addr: assert property (@(posedge clk) disable iff (!rst_b) // [RULE7]
		memRd && !st_q.ir[8] && st_q.ctrl[0] && st_q.ir[7:0] <= 8'h5f
		|-> memAddr == st_q.idxBase + {4'h0, st_q.ir[7:0]})
		else $error("indexed literal address wrong");
	a_rmw_order: assert property (@(posedge clk) disable iff (!rst_b) // [RULE8]
		$rose(memRd) |-> memRd ##1 !memRd && memWr ##1 !memWr && st_q.state == S_IDLE)
		else $error("read-modify-write out of order");
endmodule

// [carry_branch_and_bit_clear_exec_tb_top.sv]
`timescale 1ns/1ps
module carry_branch_and_bit_clear_exec_tb_top import bclr_branch_pkg::*;;
	localparam int PW = 21;
	logic clk, rst_b, instrValid, carryFlag, fetchStall, instrTaken, pcLoad, memRd, memWr;
	logic [15:0] instr;
	logic [PW-1:0] pcNext, pcTarget, tgt;
	logic [11:0] memAddr;
	logic [7:0] memRdata, memWdata, s_axi_awaddr, s_axi_araddr;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	int failures = 0, checks = 0, cyc = 0, loadAt = 0, stallCnt = 0, takenCnt = 0, tk = 0;
	logic [7:0] bOff [4] = '{8'h7f, 8'h80, 8'hff, 8'h00};
	logic bCar [4] = '{1'b1, 1'b1, 1'b0, 1'b1};
	logic [PW-1:0] bPc [4] = '{21'h000100, 21'h000010, 21'h000200, 21'h1ffffe};
	logic [PW-1:0] bExp [4] = '{21'h0001fe, 21'h1fff10, 21'h000200, 21'h1ffffe};
	logic [8:0] cAf [8] = '{9'h145, 9'h045, 9'h090, 9'h07f, 9'h010, 9'h05f, 9'h060, 9'h110};
	logic [11:0] cExp [8] = '{12'h345, 12'h045, 12'hf90, 12'h07f, 12'h210, 12'h25f, 12'hf60, 12'h310};

	carry_branch_and_bit_clear_exec #(.PC_W(PW)) carry_branch_and_bit_clear_exec_i (.clk, .rst_b, .instr,
		.instrValid, .carryFlag, .pcNext, .fetchStall, .instrTaken, .pcLoad, .pcTarget, .memAddr, .memRd,
		.memRdata, .memWr, .memWdata, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	core_mem_model core_mem_model_i (.clk, .memAddr, .memRd, .memWr, .memWdata, .memRdata);

	// ***********************************
	// clock and monitors
	// ***********************************
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// non-blocking so every reader sees the pre-edge count
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (pcLoad) begin
			loadAt <= cyc;
			tgt <= pcTarget;
		end
		stallCnt <= stallCnt + fetchStall;
		takenCnt <= takenCnt + instrTaken;
	end

	// ***********************************
	// tasks
	// ***********************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task print_verdict;
		if (failures == 0 && checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		forever begin
			@(posedge clk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid === 1'b1) break;
		end
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		forever begin
			@(posedge clk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid === 1'b1) break;
		end
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	// holds the word until taken; gap is the expected distance to the previous take
	task automatic issue(input logic [15:0] w, input logic c, input logic [PW-1:0] pn, input int gap);
		int t0;
		t0 = tk;
		instr <= w;
		carryFlag <= c;
		pcNext <= pn;
		instrValid <= 1'b1;
		for (int i = 0; i < 20; i++) begin
			@(posedge clk);
			if (instrTaken === 1'b1) break;
		end
		check(instrTaken, 1'b1);
		tk = cyc;
		if (gap != 0) check(tk - t0, gap);
	endtask

	// ***********************************
	// sequence
	// ***********************************
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		print_verdict;
	end
	initial begin
		int tb0, l0, s0, n0;
		rst_b = 1'b0;
		{instr, instrValid, carryFlag, pcNext} = '0;
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hf;
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		axiRead(REG_CTRL, rd, rsp);
		check(rd, {30'h0, CTRL_RESET});
		axiRead(REG_BANK, rd, rsp);
		check(rd, 32'h0);
		axiRead(REG_INDEX_BASE, rd, rsp);
		check(rd, 32'h0);
		axiRead(8'h10, rd, rsp);
		check(rd, 32'h0);
		check(rsp, RESP_SLVERR);
		axiWrite(8'h14, 32'h1, rsp);
		check(rsp, RESP_SLVERR);
		@(posedge clk);
		for (int i = 0; i < 4; i++) begin
			l0 = loadAt;
			s0 = stallCnt;
			issue({OPC_BRANCH_ON_CARRY, bOff[i]}, bCar[i], bPc[i], i == 0 ? 0 : 4);
			tb0 = tk;
			issue(16'h91c0, 1'b0, '0, bCar[i] ? 8 : 4);
			check(loadAt, bCar[i] ? tb0 + 3 : l0);
			if (bCar[i]) check(tgt, bExp[i]);
			check(stallCnt - s0, bCar[i] ? 4 : 0);
		end
		instrValid <= 1'b0;
		@(posedge clk);
		// the last take is counted only once this edge has passed
		n0 = takenCnt;
		instr <= 16'he300;
		instrValid <= 1'b1;
		repeat (12) @(posedge clk);
		axiWrite(REG_CTRL, 32'h0, rsp);
		instr <= 16'he200;
		repeat (12) @(posedge clk);
		instrValid <= 1'b0;
		check(takenCnt - n0, 0);
		axiWrite(REG_BANK, 32'h3, rsp);
		check(rsp, RESP_OKAY);
		axiWrite(REG_INDEX_BASE, 32'h200, rsp);
		axiRead(REG_STATUS, rd, rsp);
		// four branches and four clears so far, the last branch taken, idle
		check(rd, {8'h04, 8'h04, 10'h0, 1'b1, 1'b0, 4'h1});
		for (int i = 0; i < 8; i++) begin
			if (i % 4 == 0) axiWrite(REG_CTRL, i == 0 ? 32'h2 : 32'h3, rsp);
			issue({OPC_CLEAR_REG_BIT, 3'(i), cAf[i]}, 1'b0, '0, 0);
			instrValid <= 1'b0;
			repeat (4) @(posedge clk);
			check(memAddr, cExp[i]);
			check(core_mem_model_i.mem[cExp[i]], 8'hff & ~(8'h01 << i));
		end
		print_verdict;
	end
endmodule

// [core_mem_model.sv]
`timescale 1ns/1ps
module core_mem_model (
	// clock
	input wire logic clk,
	// data memory port
	input wire logic [11:0] memAddr,
	input wire logic memRd,
	input wire logic memWr,
	input wire logic [7:0] memWdata,
	output logic [7:0] memRdata
);
	// ***********************************
	// storage
	// ***********************************
	logic [7:0] mem [0:4095];
	logic [7:0] lastQ;
	initial begin
		foreach (mem[i]) mem[i] = 8'hff;
		lastQ = 8'h00;
	end
	always @(posedge clk) begin
		if (memWr) mem[memAddr] <= memWdata;
		if (memRd) lastQ <= mem[memAddr];
	end
	// released bus shows the inverse, so a late sample cannot pass by luck
	assign memRdata = memRd ? mem[memAddr] : ~lastQ;
endmodule

// [quarter_phase_gen.sv]
`timescale 1ns/1ps
module quarter_phase_gen import bclr_branch_pkg::*; #(
	parameter int DIV = QUARTER_CLKS
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// one-hot quarter pulses, bit 0 opens the instruction cycle
	output logic [QUARTERS-1:0] qPulse
);
	initial begin
		if (DIV < 1) $error("quarter divider must be at least 1");
	end

	typedef struct packed {
		logic [15:0] cnt;
		logic [QUARTERS-1:0] ring;
		logic [QUARTERS-1:0] pulse;
	} phase_st_t;

	phase_st_t st_q, st_d;

	always_comb begin
		st_d = st_q;
		st_d.pulse = '0;
		if (st_q.cnt == 16'(DIV - 1)) begin
			st_d.cnt = '0;
			st_d.pulse = st_q.ring;
			st_d.ring = {st_q.ring[QUARTERS-2:0], st_q.ring[QUARTERS-1]};
		end else begin
			st_d.cnt = st_q.cnt + 16'h0001;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_q <= '{cnt: '0, ring: {{(QUARTERS-1){1'b0}}, 1'b1}, pulse: '0};
		end else begin
			st_q <= st_d;
		end
	end

	assign qPulse = st_q.pulse;

	a_pulse_onehot: assert property (@(posedge clk) disable iff (!rst_b)
		$onehot0(qPulse)) else $error("quarter pulses overlap");
endmodule
